// ### hdl/pdg_top.sv
// Pulse and direction reference input with electronic gear
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module pdg_top #(
   parameter int CNT_W = 24
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   // Pulse pins
   input  wire logic        i_digital_input_five,
   input  wire logic        i_digital_input_six,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Gear outputs
   output logic      [31:0] o_slave_ref,
   output logic             o_gear_active
);
   if (CNT_W < 8 || CNT_W > 32) $error("CNT_W must lie in 8..32");
   localparam int NW = CNT_W + 32;

   logic [1:0]  ch_in;
   logic [2:0]  sync_r [2];
   logic [1:0]  level_r;
   logic [1:0]  rise;
   logic [2:0]  probe_cfg_r;
   logic [3:0]  ctrl_loc_r;
   logic [3:0]  sync_mode_r;
   logic [3:0]  master_sel_r;
   logic [7:0]  func_five_r;
   logic [7:0]  func_six_r;
   logic [15:0] lines_r;
   logic [15:0] gear_slave_r;
   logic [15:0] gear_master_r;
   logic signed [CNT_W-1:0] cnt0_r;
   logic signed [CNT_W-1:0] cnt1_r;
   logic signed [CNT_W-1:0] base_r;
   logic signed [CNT_W-1:0] sel_cnt;
   logic signed [CNT_W-1:0] delta;
   logic [CNT_W-1:0] mag;
   logic        enc_ok;
   logic        cfg_ok;
   logic        setup;
   logic        wr;
   logic        start_cmd;
   logic        stop_cmd;
   logic [31:0] rd_nxt;
   logic        hit;
   logic        launch_r;
   logic        busy_r;
   logic        neg_r;
   logic [NW-1:0] quo;
   logic        done;

   assign ch_in = {i_digital_input_six, i_digital_input_five};

   // Three stage sync; level moves once stages two and three agree
   for (genvar g = 0; g < 2; g++) begin : g_ch
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            sync_r[g]  <= 3'h0;
            level_r[g] <= 1'b0;
         end else begin
            sync_r[g] <= {sync_r[g][1:0], ch_in[g]};
            if (sync_r[g][1] == sync_r[g][2]) begin
               level_r[g] <= sync_r[g][2];
            end
         end
      end
      assign rise[g] = (sync_r[g][1] == sync_r[g][2]) && sync_r[g][2] && !level_r[g];
   end

   // Both pins must carry the encoder function
   assign enc_ok = (func_five_r == pdg_pkg::ENCODER_INPUT_FUNCTION) &&
                   (func_six_r == pdg_pkg::ENCODER_INPUT_FUNCTION);

   // Gearing is legal only under terminal control and parameter gear mode
   assign cfg_ok = enc_ok &&
      (probe_cfg_r == pdg_pkg::PULSE_DIR_MODE || probe_cfg_r == pdg_pkg::DUAL_PULSE_COUNT_MODE) &&
      (ctrl_loc_r == pdg_pkg::CTRL_TERMINAL) &&
      (sync_mode_r == pdg_pkg::PARAM_GEAR_MODE) &&
      (master_sel_r == pdg_pkg::MASTER_PROBE0 || master_sel_r == pdg_pkg::MASTER_PROBE1) &&
      (lines_r != 16'h0000) && (gear_master_r != 16'h0000);

   // Pulse counters
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cnt0_r <= '0;
         cnt1_r <= '0;
      end else if (enc_ok) begin
         if (probe_cfg_r == pdg_pkg::DUAL_PULSE_COUNT_MODE) begin
            cnt0_r <= cnt0_r + CNT_W'(rise[0]);
            cnt1_r <= cnt1_r + CNT_W'(rise[1]);
         end else if (probe_cfg_r == pdg_pkg::PULSE_DIR_MODE && rise[0]) begin
            if (level_r[1]) begin
               cnt0_r <= cnt0_r + CNT_W'(1);
            end else begin
               cnt0_r <= cnt0_r - CNT_W'(1);
            end
         end
      end
   end

   // Master channel select and signed distance since start
   assign sel_cnt = (master_sel_r == pdg_pkg::MASTER_PROBE1) ? cnt1_r : cnt0_r;
   assign delta   = sel_cnt - base_r;
   assign mag     = delta[CNT_W-1] ? CNT_W'(-delta) : CNT_W'(delta);

   // APB decode
   assign setup     = i_psel && !i_penable;
   assign wr        = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr;
   assign start_cmd = wr && (i_paddr == pdg_pkg::ADDR_CMD) && i_pwdata[pdg_pkg::CMD_START_BIT];
   assign stop_cmd  = wr && (i_paddr == pdg_pkg::ADDR_CMD) && i_pwdata[pdg_pkg::CMD_STOP_BIT];

   // Read mux, sampled in the setup cycle
   always_comb begin
      rd_nxt = 32'h0000_0000;
      hit    = 1'b1;
      if (i_paddr == pdg_pkg::ADDR_CFG) begin
         rd_nxt = {16'h0000, master_sel_r, sync_mode_r, ctrl_loc_r, 1'b0, probe_cfg_r};
      end else if (i_paddr == pdg_pkg::ADDR_INFUNC) begin
         rd_nxt = {16'h0000, func_six_r, func_five_r};
      end else if (i_paddr == pdg_pkg::ADDR_LINES) begin
         rd_nxt = {16'h0000, lines_r};
      end else if (i_paddr == pdg_pkg::ADDR_GEAR) begin
         rd_nxt = {gear_master_r, gear_slave_r};
      end else if (i_paddr == pdg_pkg::ADDR_CMD) begin
         rd_nxt = 32'h0000_0000;
      end else if (i_paddr == pdg_pkg::ADDR_STATUS) begin
         rd_nxt = {30'h0000_0000, cfg_ok, o_gear_active};
      end else if (i_paddr == pdg_pkg::ADDR_CNT0) begin
         rd_nxt = 32'(cnt0_r);
      end else if (i_paddr == pdg_pkg::ADDR_CNT1) begin
         rd_nxt = 32'(cnt1_r);
      end else if (i_paddr == pdg_pkg::ADDR_REF) begin
         rd_nxt = o_slave_ref;
      end else begin
         hit = 1'b0;
      end
   end

   // One wait-free access phase; answer registered at the setup edge
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end else begin
         o_pready  <= setup;
         o_pslverr <= setup && !hit;
         if (setup) begin
            o_prdata <= hit ? rd_nxt : 32'h0000_0000;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         probe_cfg_r   <= 3'h0;
         ctrl_loc_r    <= 4'h0;
         sync_mode_r   <= 4'h0;
         master_sel_r  <= 4'h0;
         func_five_r   <= 8'h00;
         func_six_r    <= 8'h00;
         lines_r       <= pdg_pkg::LINES_RST;
         gear_slave_r  <= pdg_pkg::RATIO_RST;
         gear_master_r <= pdg_pkg::RATIO_RST;
      end else if (wr) begin
         if (i_paddr == pdg_pkg::ADDR_CFG) begin
            probe_cfg_r  <= i_pwdata[2:0];
            ctrl_loc_r   <= i_pwdata[7:4];
            sync_mode_r  <= i_pwdata[11:8];
            master_sel_r <= i_pwdata[15:12];
         end else if (i_paddr == pdg_pkg::ADDR_INFUNC) begin
            func_five_r <= i_pwdata[7:0];
            func_six_r  <= i_pwdata[15:8];
         end else if (i_paddr == pdg_pkg::ADDR_LINES) begin
            lines_r <= i_pwdata[15:0];
         end else if (i_paddr == pdg_pkg::ADDR_GEAR) begin
            gear_slave_r  <= i_pwdata[15:0];
            gear_master_r <= i_pwdata[31:16];
         end
      end
   end

   // Gear on only by explicit start; stop or a broken setup drops it
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_gear_active <= 1'b0;
         base_r        <= '0;
      end else if (stop_cmd || !cfg_ok) begin
         o_gear_active <= 1'b0;
      end else if (start_cmd) begin
         o_gear_active <= 1'b1;
         base_r        <= sel_cnt;
      end
   end

   // Continuous recompute; latency about NW cycles, well under a pulse period
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         launch_r <= 1'b0;
         busy_r   <= 1'b0;
         neg_r    <= 1'b0;
      end else begin
         launch_r <= !busy_r && !launch_r;
         if (launch_r) begin
            busy_r <= 1'b1;
            neg_r  <= delta[CNT_W-1];
         end else if (done) begin
            busy_r <= 1'b0;
         end
      end
   end

   // Reference = count * slave * units / (master * lines)
   pdg_div #(
      .NW (NW),
      .DW (32)
   ) u_div (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_start (launch_r),
      .i_num   ({NW'(mag) * NW'(gear_slave_r) << pdg_pkg::REV_SHIFT}),
      .i_den   (32'(gear_master_r) * 32'(lines_r)),
      .o_quo   (quo),
      .o_done  (done)
   );

   // Slave reference follows only while gearing runs
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_slave_ref <= 32'h0000_0000;
      end else if (done && o_gear_active) begin
         o_slave_ref <= neg_r ? 32'(-quo[31:0]) : quo[31:0];
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_dual_rise0;
      enc_ok && probe_cfg_r == pdg_pkg::DUAL_PULSE_COUNT_MODE && rise[0];
   endsequence
   property p_dual_count;
      s_dual_rise0 |=> cnt0_r == $past(cnt0_r) + CNT_W'(1);
   endproperty
   a_dual_count: assert property (p_dual_count) else $error("dual count missed");
   property p_pulse_dir_mode;
      enc_ok && probe_cfg_r == pdg_pkg::PULSE_DIR_MODE && rise[0] && level_r[1]
         |=> cnt0_r == $past(cnt0_r) + CNT_W'(1);
   endproperty
   a_pulse_dir_mode: assert property (p_pulse_dir_mode) else $error("direction high not up");
   property p_pd_down;
      enc_ok && probe_cfg_r == pdg_pkg::PULSE_DIR_MODE && rise[0] && !level_r[1]
         |=> cnt0_r == $past(cnt0_r) - CNT_W'(1);
   endproperty
   a_pd_down: assert property (p_pd_down) else $error("direction low not down");
   property p_pd_cnt1_hold;
      probe_cfg_r == pdg_pkg::PULSE_DIR_MODE |=> $stable(cnt1_r);
   endproperty
   a_pd_cnt1_hold: assert property (p_pd_cnt1_hold) else $error("cnt1 moved in dir mode");
   property p_enc_gate;
      !enc_ok |=> $stable(cnt0_r) && $stable(cnt1_r);
   endproperty
   a_enc_gate: assert property (p_enc_gate) else $error("count without encoder function");
   property p_lines_reset;
      $past(i_reset) |-> lines_r == pdg_pkg::LINES_RST;
   endproperty
   a_lines_reset: assert property (disable iff (1'b0) p_lines_reset) else $error("lines reset wrong");
   // Active lags a config write by one edge, so the setup is judged one cycle back
   property p_loc_mode;
      o_gear_active |-> $past(ctrl_loc_r == pdg_pkg::CTRL_TERMINAL && sync_mode_r == pdg_pkg::PARAM_GEAR_MODE);
   endproperty
   a_loc_mode: assert property (p_loc_mode) else $error("gear on with wrong location or mode");
   property p_sel;
      master_sel_r == pdg_pkg::MASTER_PROBE1 |-> sel_cnt == cnt1_r;
   endproperty
   a_sel: assert property (p_sel) else $error("selector 7 not channel one");
   sequence s_start; start_cmd && cfg_ok && !stop_cmd; endsequence
   property p_start;
      $rose(o_gear_active) |-> $past(start_cmd);
   endproperty
   a_start: assert property (p_start) else $error("gear started without command");
   property p_start_takes;
      s_start |=> o_gear_active;
   endproperty
   a_start_takes: assert property (p_start_takes) else $error("start ignored");
endmodule : pdg_top

// ### hdl/pdg_pkg.sv
// Package: register map, codes and widths for pulse direction gearing
package pdg_pkg;
   // Register byte offsets
   localparam logic [7:0] ADDR_CFG    = 8'h00;
   localparam logic [7:0] ADDR_INFUNC = 8'h04;
   localparam logic [7:0] ADDR_LINES  = 8'h08;
   localparam logic [7:0] ADDR_GEAR   = 8'h0c;
   localparam logic [7:0] ADDR_CMD    = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_CNT0   = 8'h18;
   localparam logic [7:0] ADDR_CNT1   = 8'h1c;
   localparam logic [7:0] ADDR_REF    = 8'h20;
   // Field positions
   localparam int CMD_START_BIT = 0;
   localparam int CMD_STOP_BIT  = 1;
   // Configuration codes
   localparam logic [2:0] PULSE_DIR_MODE        = 3'h2;
   localparam logic [2:0] DUAL_PULSE_COUNT_MODE = 3'h4;
   localparam logic [7:0] ENCODER_INPUT_FUNCTION = 8'h1d;
   localparam logic [3:0] CTRL_TERMINAL  = 4'h1;
   localparam logic [3:0] PARAM_GEAR_MODE = 4'h4;
   localparam logic [3:0] MASTER_PROBE0  = 4'h6;
   localparam logic [3:0] MASTER_PROBE1  = 4'h7;
   // Reset values
   localparam logic [15:0] LINES_RST = 16'h0001;
   localparam logic [15:0] RATIO_RST = 16'h0001;
   // Reference units per revolution as a shift
   localparam int REV_SHIFT = 16;
   // Divider sequencer states
   typedef enum logic [0:0] {
      DIV_IDLE = 1'b0,
      DIV_BUSY = 1'b1
   } pdg_div_state_type;
endpackage : pdg_pkg

// ### hdl/pdg_div.sv
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
module pdg_div #(
   parameter int NW = 56,
   parameter int DW = 32
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_reset,
   // Request
   input  wire logic          i_start,
   input  wire logic [NW-1:0] i_num,
   input  wire logic [DW-1:0] i_den,
   // Answer
   output logic      [NW-1:0] o_quo,
   output logic               o_done
);
   if (NW < 2 || DW < 2) $error("pdg_div widths too small");
   localparam int PW = NW + DW;

   pdg_pkg::pdg_div_state_type state_r;
   logic [NW-1:0] num_r;
   logic [DW-1:0] rem_r;
   logic [DW-1:0] den_r;
   logic [7:0]    bit_r;
   logic [DW:0]   trial;

   // Partial remainder with next numerator bit
   assign trial = {rem_r, o_quo[NW-1]};

   // Shift and subtract sequence
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         state_r <= pdg_pkg::DIV_IDLE;
         num_r   <= '0;
         rem_r   <= '0;
         den_r   <= '0;
         bit_r   <= '0;
         o_quo   <= '0;
         o_done  <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state_r)
            pdg_pkg::DIV_IDLE: begin
               if (i_start) begin
                  o_quo   <= i_num;
                  num_r   <= i_num;
                  den_r   <= i_den;
                  rem_r   <= '0;
                  bit_r   <= 8'(NW - 1);
                  state_r <= pdg_pkg::DIV_BUSY;
               end
            end
            pdg_pkg::DIV_BUSY: begin
               if (trial >= {1'b0, den_r}) begin
                  rem_r <= DW'(trial - {1'b0, den_r});
                  o_quo <= {o_quo[NW-2:0], 1'b1};
               end else begin
                  rem_r <= trial[DW-1:0];
                  o_quo <= {o_quo[NW-2:0], 1'b0};
               end
               if (bit_r == 8'h00) begin
                  state_r <= pdg_pkg::DIV_IDLE;
                  o_done  <= 1'b1;
               end
               bit_r <= bit_r - 8'h01;
            end
            default: state_r <= pdg_pkg::DIV_IDLE;
         endcase
      end
   end

   // Quotient and remainder must rebuild the captured numerator; zero divisor is undefined
   property p_div_exact;
      @(posedge i_clk) disable iff (i_reset)
         o_done && den_r != '0 |-> PW'(o_quo) * PW'(den_r) + PW'(rem_r) == PW'(num_r) && rem_r < den_r;
   endproperty
   a_div_exact: assert property (p_div_exact) else $error("quotient and remainder do not rebuild numerator");
endmodule : pdg_div

// ### verif/pdg_pulse_gen.sv
// Pulse and direction generator model driving the two counting pins
`timescale 1ns/1ps
module pdg_pulse_gen #(
   parameter int HALF = 70
) (
   // Clock of the bench
   input  wire logic i_clk,
   // Pins toward the drive
   output logic      o_pin_zero,
   output logic      o_pin_one
);
   // Both pins idle low, push-pull
   initial begin
      o_pin_zero = 1'b0;
      o_pin_one  = 1'b0;
   end

   // Half period of 70 clocks keeps the pulse rate near 285 kHz
   task automatic burst(input int ch, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk);
         if (ch == 0)
            o_pin_zero <= 1'b1;
         else
            o_pin_one <= 1'b1;
         repeat (HALF) @(posedge i_clk);
         if (ch == 0)
            o_pin_zero <= 1'b0;
         else
            o_pin_one <= 1'b0;
         repeat (HALF - 1) @(posedge i_clk);
      end
   endtask : burst

   // Direction settles long before the next pulse edge
   task automatic set_dir(input logic v);
      @(posedge i_clk);
      o_pin_one <= v;
      repeat (HALF) @(posedge i_clk);
   endtask : set_dir
endmodule : pdg_pulse_gen

// ### verif/pulse_direction_gearing_tb.sv
// Self-checking bench for the pulse direction gearing block
`timescale 1ns/1ps
module pulse_direction_gearing_tb;
   logic        i_clk;
   logic        i_reset;
   logic        pin_zero;
   logic        pin_one;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] slave_ref;
   logic        gear_active;
   logic [31:0] rdata;
   logic        rerr;
   logic [31:0] c0;
   logic [31:0] c1;
   int          failures;
   int          checks;
   int          cycles;
   localparam logic [31:0] ENC2 = {16'h0, pdg_pkg::ENCODER_INPUT_FUNCTION, pdg_pkg::ENCODER_INPUT_FUNCTION};

   pdg_top #(.CNT_W(24)) uut (
      .i_clk(i_clk), .i_reset(i_reset),
      .i_digital_input_five(pin_zero), .i_digital_input_six(pin_one),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .o_slave_ref(slave_ref), .o_gear_active(gear_active)
   );
   pdg_pulse_gen gen (.i_clk(i_clk), .o_pin_zero(pin_zero), .o_pin_one(pin_one));

   // Free-running 40 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   task automatic test_done;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   // Hang guard, well above the roughly 7200 cycles the run needs
   initial begin
      cycles = 0;
      forever begin
         @(posedge i_clk);
         cycles++;
         if (cycles == 20000) begin
            failures++;
            test_done();
         end
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask : chk

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge i_clk);
      penable <= 1'b1;
      // Only the hang guard ends a wait that never sees pready
      do begin
         @(posedge i_clk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk("write error flag", 32'h0, {31'h0, rerr});
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rdata);
      chk("read error flag", 32'h0, {31'h0, rerr});
   endtask : rdchk

   function automatic logic [31:0] cfg(input logic [2:0] pc, input logic [3:0] loc, input logic [3:0] md,
                                       input logic [3:0] sel);
      return {16'h0, sel, md, loc, 1'b0, pc};
   endfunction : cfg

   task automatic t_reset;
      rdchk("lines", pdg_pkg::ADDR_LINES, 32'h00000001);
      rdchk("gear", pdg_pkg::ADDR_GEAR, 32'h00010001);
      rdchk("status", pdg_pkg::ADDR_STATUS, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped error flag", 32'h1, {31'h0, rerr});
      chk("unmapped data", 32'h0, rdata);
   endtask : t_reset

   task automatic t_dual;
      wr(pdg_pkg::ADDR_INFUNC, ENC2);
      wr(pdg_pkg::ADDR_CFG, cfg(pdg_pkg::DUAL_PULSE_COUNT_MODE, 4'h0, 4'h0, 4'h0));
      apb(1'b0, pdg_pkg::ADDR_CNT0, 32'h0);
      c0 = rdata;
      apb(1'b0, pdg_pkg::ADDR_CNT1, 32'h0);
      c1 = rdata;
      gen.burst(0, 3);
      gen.burst(1, 5);
      rdchk("count zero", pdg_pkg::ADDR_CNT0, c0 + 32'd3);
      rdchk("count one", pdg_pkg::ADDR_CNT1, c1 + 32'd5);
      wr(pdg_pkg::ADDR_INFUNC, {16'h0, 8'h00, pdg_pkg::ENCODER_INPUT_FUNCTION});
      gen.burst(0, 2);
      rdchk("count zero refused", pdg_pkg::ADDR_CNT0, c0 + 32'd3);
      wr(pdg_pkg::ADDR_INFUNC, ENC2);
   endtask : t_dual

   task automatic t_dir;
      wr(pdg_pkg::ADDR_CFG, cfg(pdg_pkg::PULSE_DIR_MODE, 4'h0, 4'h0, 4'h0));
      apb(1'b0, pdg_pkg::ADDR_CNT0, 32'h0);
      c0 = rdata;
      gen.set_dir(1'b1);
      gen.burst(0, 4);
      rdchk("count up", pdg_pkg::ADDR_CNT0, c0 + 32'd4);
      gen.set_dir(1'b0);
      gen.burst(0, 6);
      rdchk("count down", pdg_pkg::ADDR_CNT0, c0 - 32'd2);
   endtask : t_dir

   // Lines 4, slave 3, master 2: one pulse is 3/8 of 65536 units
   task automatic t_gear;
      wr(pdg_pkg::ADDR_LINES, 32'h4);
      wr(pdg_pkg::ADDR_GEAR, 32'h00020003);
      wr(pdg_pkg::ADDR_CFG, cfg(pdg_pkg::PULSE_DIR_MODE, 4'h0, pdg_pkg::PARAM_GEAR_MODE, pdg_pkg::MASTER_PROBE0));
      wr(pdg_pkg::ADDR_CMD, 32'h1);
      repeat (3) @(posedge i_clk);
      chk("active without terminal", 32'h0, {31'h0, gear_active});
      wr(pdg_pkg::ADDR_CFG, cfg(pdg_pkg::PULSE_DIR_MODE, pdg_pkg::CTRL_TERMINAL, 4'h0, pdg_pkg::MASTER_PROBE0));
      wr(pdg_pkg::ADDR_CMD, 32'h1);
      repeat (3) @(posedge i_clk);
      chk("active without gear mode", 32'h0, {31'h0, gear_active});
      wr(pdg_pkg::ADDR_CFG, cfg(pdg_pkg::PULSE_DIR_MODE, pdg_pkg::CTRL_TERMINAL, pdg_pkg::PARAM_GEAR_MODE,
                                pdg_pkg::MASTER_PROBE0));
      gen.set_dir(1'b1);
      gen.burst(0, 2);
      chk("reference before start", 32'h0, slave_ref);
      wr(pdg_pkg::ADDR_CMD, 32'h1);
      rdchk("status running", pdg_pkg::ADDR_STATUS, 32'h3);
      gen.burst(0, 8);
      repeat (80) @(posedge i_clk);
      chk("reference up", 32'h00030000, slave_ref);
      gen.set_dir(1'b0);
      gen.burst(0, 12);
      repeat (80) @(posedge i_clk);
      rdchk("reference down", pdg_pkg::ADDR_REF, 32'hfffe8000);
      wr(pdg_pkg::ADDR_CMD, 32'h2);
      repeat (3) @(posedge i_clk);
      chk("active after stop", 32'h0, {31'h0, gear_active});
   endtask : t_gear

   // Channel one as master at one pulse per revolution
   task automatic t_sel1;
      wr(pdg_pkg::ADDR_LINES, 32'h1);
      wr(pdg_pkg::ADDR_GEAR, 32'h00010001);
      wr(pdg_pkg::ADDR_CFG, cfg(pdg_pkg::DUAL_PULSE_COUNT_MODE, pdg_pkg::CTRL_TERMINAL,
                                pdg_pkg::PARAM_GEAR_MODE, pdg_pkg::MASTER_PROBE1));
      wr(pdg_pkg::ADDR_CMD, 32'h1);
      gen.burst(1, 2);
      gen.burst(0, 3);
      repeat (80) @(posedge i_clk);
      chk("reference channel one", 32'h00020000, slave_ref);
      wr(pdg_pkg::ADDR_CMD, 32'h2);
   endtask : t_sel1

   // Main sequence
   initial begin
      failures = 0;
      checks   = 0;
      i_reset  = 1'b1;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 8'h00;
      pwdata   = 32'h0;
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      chk("reference in reset", 32'h0, slave_ref);
      t_reset();
      t_dual();
      t_dir();
      t_gear();
      t_sel1();
      test_done();
   end
endmodule : pulse_direction_gearing_tb
